// ==== src/srmc_mode_ctrl.sv ====
// Operating-mode controller for a dual-channel rectifier gate driver.
// Assumes rail and drain comparator levels synchronous to clk.
//
// How it works
// - Only channel one frequency decides standby
// - Low count for one window enters standby
// - Standby stops both gates, low current
// - Standby still counts body-diode cycles
// - High count in one window exits standby
// - First switching cycle gets no gate
// - Standby keeps monitor and active pull-down
// - Lockout from reset or below off threshold
// - Leave lockout only above on threshold
// - Lockout pull-down active above 2 V, else weak
// - Run mode otherwise; gates drive rectifiers
// - Arm only after off blanking expires
`timescale 1ns/1ps
`default_nettype none
`include "srmc_params.svh"
module srmc_mode_ctrl
    import srmc_pkg::*;
#(
    parameter int QUAL_CYC = `SRMC_QUAL_CYC,    // Window length, cycles
    parameter int LOW_CNT  = `SRMC_LOW_CNT,     // Edges below: too slow
    parameter int HIGH_CNT = `SRMC_HIGH_CNT     // Edges above: fast
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic rail_above_on,     // Rail above rail_on_threshold
    input  wire logic rail_above_off,    // Rail above rail_off_threshold
    input  wire logic rail_above_2v,     // Rail above 2 V
    input  wire logic drain_sense_one,   // Drain one above arm_threshold
    input  wire logic drain_sense_two,   // Drain two above arm_threshold
    input  wire logic conduct_one,       // Channel one conducting
    input  wire logic conduct_two,       // Channel two conducting
    output logic      gate_out_one,      // Gate one drive high
    output logic      gate_out_two,      // Gate two drive high
    output logic      active_pulldown,   // Strong pull-down to ground
    output logic      weak_pulldown,     // Weak pull-down to ground
    output logic      standby_current,   // Reduced supply state
    output logic      lockout_current,   // Lockout supply state
    output logic [1:0] mode_out          // Current operating mode
);
    // ==========================================================
    // State
    typedef struct packed {
        srmc_mode_t  mode;
        logic [18:0] win_cnt;
        logic [15:0] edge_cnt;
        logic        drain_prev;
    } srmc_st_t;
    srmc_st_t st_reg;
    srmc_st_t st_next;

    localparam logic [18:0] WIN_LAST  = 19'(QUAL_CYC - 1);
    localparam logic [15:0] LOW_LIM   = 16'(LOW_CNT);
    localparam logic [15:0] HIGH_LIM  = 16'(HIGH_CNT);

    logic run_en;       // Channel logic enable
    logic ch_one_on;    // Channel one gate request
    logic ch_two_on;    // Channel two gate request
    logic edge_one;     // Channel one switching event
    logic win_end;      // Window expiry

    // ==========================================================
    // Channel one rising edges, the sole frequency source
    assign edge_one = drain_sense_one && !st_reg.drain_prev;
    assign win_end  = (st_reg.win_cnt == WIN_LAST);

    // Mode and frequency monitor next state
    always_comb begin
        st_next = st_reg;
        st_next.drain_prev = drain_sense_one;
        // Window timing and edge counting
        if (win_end) begin
            // An edge on the last cycle opens the next window's count
            st_next.win_cnt = 19'h0;
            st_next.edge_cnt = {15'h0, edge_one};
        end else begin
            st_next.win_cnt = st_reg.win_cnt + 19'h1;
            if (edge_one && st_reg.edge_cnt != 16'hffff) begin
                st_next.edge_cnt = st_reg.edge_cnt + 16'h1;
            end
        end
        case (st_reg.mode)
            SRMC_LOCKOUT: begin
                // Leave only above the on threshold
                if (rail_above_on) begin
                    st_next.mode = SRMC_RUN;
                    st_next.win_cnt = 19'h0;
                    st_next.edge_cnt = 16'h0;
                end
            end
            SRMC_RUN: begin
                if (!rail_above_off) begin
                    st_next.mode = SRMC_LOCKOUT;
                end else if (win_end && st_reg.edge_cnt < LOW_LIM) begin
                    st_next.mode = SRMC_STANDBY;
                end
            end
            SRMC_STANDBY: begin
                if (!rail_above_off) begin
                    st_next.mode = SRMC_LOCKOUT;
                end else if (win_end && st_reg.edge_cnt > HIGH_LIM) begin
                    st_next.mode = SRMC_RUN;
                end
            end
            default: begin
                st_next.mode = SRMC_LOCKOUT;
            end
        endcase
        if (st_reg.mode == SRMC_LOCKOUT && !rail_above_on) begin
            st_next.win_cnt = 19'h0;
            st_next.edge_cnt = 16'h0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Gate channels, enabled in run mode only
    assign run_en = (st_reg.mode == SRMC_RUN);

    srmc_arm_channel u_ch_one (
        .clk        (clk),
        .reset_n    (reset_n),
        .enable     (run_en),
        .drain_high (drain_sense_one),
        .conduct    (conduct_one),
        .other_on   (ch_two_on),
        .gate_on    (ch_one_on)
    );

    srmc_arm_channel u_ch_two (
        .clk        (clk),
        .reset_n    (reset_n),
        .enable     (run_en),
        .drain_high (drain_sense_two),
        .conduct    (conduct_two),
        .other_on   (ch_one_on),
        .gate_on    (ch_two_on)
    );

    // Outputs
    assign gate_out_one = ch_one_on && run_en;
    assign gate_out_two = ch_two_on && run_en;
    // Pull-downs: active in standby and lockout above 2 V
    assign active_pulldown = !run_en &&
                             (st_reg.mode == SRMC_STANDBY || rail_above_2v);
    assign weak_pulldown   = (st_reg.mode == SRMC_LOCKOUT) && !rail_above_2v;
    assign standby_current = (st_reg.mode == SRMC_STANDBY);
    assign lockout_current = (st_reg.mode == SRMC_LOCKOUT);
    assign mode_out        = st_reg.mode;

    // ==========================================================
    // Assertions
    property p_gates_off_idle;
        @(posedge clk) disable iff (!reset_n)
        !run_en |-> !gate_out_one && !gate_out_two;
    endproperty
    a_gates_off_idle: assert property (p_gates_off_idle)
        else $error("gate driven outside run");

    property p_enter_standby;
        @(posedge clk) disable iff (!reset_n)
        (run_en && rail_above_off && win_end && st_reg.edge_cnt < LOW_LIM)
        |=> st_reg.mode == SRMC_STANDBY;
    endproperty
    a_enter_standby: assert property (p_enter_standby)
        else $error("missed standby entry");

    property p_exit_standby;
        @(posedge clk) disable iff (!reset_n)
        (st_reg.mode == SRMC_STANDBY && rail_above_off && win_end
         && st_reg.edge_cnt > HIGH_LIM) |=> run_en;
    endproperty
    a_exit_standby: assert property (p_exit_standby)
        else $error("missed standby exit");

    property p_lockout_hold;
        @(posedge clk) disable iff (!reset_n)
        (st_reg.mode == SRMC_LOCKOUT && !rail_above_on)
        |=> st_reg.mode == SRMC_LOCKOUT;
    endproperty
    a_lockout_hold: assert property (p_lockout_hold)
        else $error("left lockout early");

    property p_rail_drop;
        @(posedge clk) disable iff (!reset_n)
        !rail_above_off |=> st_reg.mode == SRMC_LOCKOUT;
    endproperty
    a_rail_drop: assert property (p_rail_drop)
        else $error("no lockout on rail drop");

    property p_pulldown;
        @(posedge clk) disable iff (!reset_n)
        lockout_current |-> (active_pulldown == rail_above_2v)
                            && (weak_pulldown == !rail_above_2v);
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("wrong lockout pull-down");

    property p_counters_cleared;
        @(posedge clk) disable iff (!reset_n)
        (lockout_current && rail_above_on) |=>
            run_en && st_reg.win_cnt == 19'h0 && st_reg.edge_cnt == 16'h0;
    endproperty
    a_counters_cleared: assert property (p_counters_cleared)
        else $error("counters not cleared");

    property p_standby_pd;
        @(posedge clk) disable iff (!reset_n)
        standby_current |-> active_pulldown && !weak_pulldown;
    endproperty
    a_standby_pd: assert property (p_standby_pd)
        else $error("standby pull-down missing");

    property p_interlock;
        @(posedge clk) disable iff (!reset_n)
        !(gate_out_one && gate_out_two);
    endproperty
    a_interlock: assert property (p_interlock)
        else $error("both gates on");
endmodule : srmc_mode_ctrl
`default_nettype wire

// ==== src/srmc_params.svh ====
// Timing and threshold constants for the operating-mode controller.
// Assumes a 40 MHz system clock; included by the package and modules.
`ifndef SRMC_PARAMS_SVH
`define SRMC_PARAMS_SVH
// ==========================================================
// Clock and qualification window
`define SRMC_CLK_HZ         40000000
`define SRMC_QUAL_WIN_US    7500
`define SRMC_QUAL_CYC       ((`SRMC_CLK_HZ / 1000) * `SRMC_QUAL_WIN_US / 1000)
// Frequency limits in Hz and as edge counts per window
`define SRMC_LOW_FREQ_HZ    9000
`define SRMC_HIGH_FREQ_HZ   15600
`define SRMC_LOW_CNT  ((`SRMC_LOW_FREQ_HZ * `SRMC_QUAL_WIN_US) / 1000000)
`define SRMC_HIGH_CNT ((`SRMC_HIGH_FREQ_HZ * `SRMC_QUAL_WIN_US) / 1000000)
// Off-time blanking in ns and in cycles (rounded up)
`define SRMC_OFF_BLANK_NS   650
`define SRMC_PERIOD_NS      25
`define SRMC_OFF_BLANK_CYC  ((`SRMC_OFF_BLANK_NS + `SRMC_PERIOD_NS - 1) / `SRMC_PERIOD_NS)
`endif

// ==== src/srmc_pkg.sv ====
// Types shared by the operating-mode controller files.
// Assumes srmc_params.svh is on the include path.
`include "srmc_params.svh"
package srmc_pkg;
    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        SRMC_LOCKOUT,
        SRMC_STANDBY,
        SRMC_RUN
    } srmc_mode_t;
endpackage : srmc_pkg

// ==== src/srmc_arm_channel.sv ====
// One rectifier channel: arming after off-time blanking and gate drive.
// Assumes drain-sense comparator levels synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "srmc_params.svh"
module srmc_arm_channel
    import srmc_pkg::*;
#(
    parameter int BLANK_CYC = `SRMC_OFF_BLANK_CYC
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic enable,         // Run mode
    input  wire logic drain_high,     // Drain 1.5 V above source
    input  wire logic conduct,        // Drain below turn-on level
    input  wire logic other_on,       // Interlock from other channel
    output logic      gate_on         // Gate drive request
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] blank_cnt;
        logic       armed;
        logic       gate;
        logic       seen_first;
    } srmc_ch_t;
    srmc_ch_t st_reg;
    srmc_ch_t st_next;
    localparam logic [7:0] BLANK_LOAD = 8'(BLANK_CYC);

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        if (!enable) begin
            // Gates held off and arming dropped outside run mode
            st_next.gate = 1'b0;
            st_next.armed = 1'b0;
            st_next.seen_first = 1'b0;
            st_next.blank_cnt = 8'h00;
        end else begin
            if (st_reg.gate && !conduct) begin
                st_next.gate = 1'b0;
            end
            // Blanking counts from drain rising 1.5 V
            if (!st_reg.gate && drain_high && !st_reg.armed) begin
                if (st_reg.blank_cnt == BLANK_LOAD) begin
                    st_next.armed = 1'b1;
                    st_next.blank_cnt = 8'h00;
                end else begin
                    st_next.blank_cnt = st_reg.blank_cnt + 8'h01;
                end
            end else if (!drain_high) begin
                st_next.blank_cnt = 8'h00;
            end
            // First conduction cycle is ignored
            if (conduct && !st_reg.gate && !st_reg.seen_first) begin
                st_next.seen_first = 1'b1;
                st_next.armed = 1'b0;
            end else if (conduct && st_reg.armed && !other_on
                         && !st_reg.gate) begin
                st_next.gate = 1'b1;
                st_next.armed = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign gate_on = st_reg.gate;

    // Gate turns on only from an armed state
    property p_arm_before_on;
        @(posedge clk) disable iff (!reset_n)
        $rose(st_reg.gate) |-> $past(st_reg.armed);
    endproperty
    a_arm_before_on: assert property (p_arm_before_on)
        else $error("gate rose without arming");
endmodule : srmc_arm_channel
`default_nettype wire

// ==== sim/srmc_rect_model.sv ====
// Behavioural pair of rectifier transistors of a resonant converter.
// Assumes clk is the controller clock; levels change after its edges.
`timescale 1ns/1ps
`default_nettype none
module srmc_rect_model #(
    parameter int HALF = 40             // Half switching period, cycles
) (
    input  wire logic clk,
    input  wire logic run_one,          // Channel one switches
    input  wire logic run_two,          // Channel two switches
    output logic      drain_sense_one,
    output logic      drain_sense_two,
    output logic      conduct_one,
    output logic      conduct_two
);
    // ==========================================================
    // Half-period counter and phase
    int   cnt_reg = 0;                  // Cycles into this half
    logic ph_reg  = 1'b0;               // High: channel one conducts

    // Complementary halves: one side conducts while the other blocks
    always_ff @(posedge clk) begin
        if (cnt_reg == HALF - 1) begin
            cnt_reg <= 0;
            ph_reg  <= ~ph_reg;
        end else begin
            cnt_reg <= cnt_reg + 1;
        end
    end

    // Stopped channel shows no drain swing and no conduction
    assign drain_sense_one = run_one & ~ph_reg;
    assign conduct_one     = run_one & ph_reg;
    assign drain_sense_two = run_two & ph_reg;
    assign conduct_two     = run_two & ~ph_reg;
endmodule : srmc_rect_model
`default_nettype wire

// ==== sim/test_sr_operating_mode_controller.sv ====
// Self-checking bench for the operating-mode controller.
// Assumes srmc_pkg and the rectifier model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_sr_operating_mode_controller
    import srmc_pkg::*;
;
    // ==========================================================
    // Signals
    localparam int QCYC = 1000;         // Shortened window
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       on_r = 1'b0, off_r = 1'b0, v2_r = 1'b0;
    logic       run_one = 1'b0, run_two = 1'b0;
    logic       ds1, ds2, cd1, cd2;
    logic       g1, g2, apd, wpd, sbc, loc;
    logic [1:0] mode;
    int         n_errors = 0;
    int         comparisons = 0;

    always #12.5 clk = ~clk;

    srmc_rect_model #(.HALF(40)) srmc_rect_model_inst (.clk(clk),
        .run_one(run_one), .run_two(run_two), .drain_sense_one(ds1),
        .drain_sense_two(ds2), .conduct_one(cd1), .conduct_two(cd2));
    srmc_mode_ctrl #(.QUAL_CYC(QCYC), .LOW_CNT(2), .HIGH_CNT(4))
        srmc_mode_ctrl_inst (.clk(clk), .reset_n(reset_n),
        .rail_above_on(on_r), .rail_above_off(off_r),
        .rail_above_2v(v2_r), .drain_sense_one(ds1), .drain_sense_two(ds2),
        .conduct_one(cd1), .conduct_two(cd2), .gate_out_one(g1),
        .gate_out_two(g2), .active_pulldown(apd), .weak_pulldown(wpd),
        .standby_current(sbc), .lockout_current(loc), .mode_out(mode));

    // ==========================================================
    // Compare, wait and closing tasks
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_mode(input logic [1:0] got, input srmc_mode_t exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_mode
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wait_mode(input srmc_mode_t exp, input int lim);
        // Step off the clock edge so the mode is read settled
        #1;
        for (int i = 0; i < lim && mode !== exp; i++) tick(1);
        chk_mode(mode, exp);
    endtask : wait_mode
    task automatic test_done;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // Gates never together, never high outside run
    always @(negedge clk) begin
        chk_bit(g1 & g2, 1'b0);
        chk_bit((g1 | g2) & (mode !== SRMC_RUN), 1'b0);
    end

    // ==========================================================
    // Scenarios
    task automatic t_lockout;
        chk_mode(mode, SRMC_LOCKOUT);
        chk_bit(loc, 1'b1);
        chk_bit(wpd, 1'b1);
        chk_bit(apd, 1'b0);
        @(posedge clk);
        v2_r  <= 1'b1;
        off_r <= 1'b1;
        run_one <= 1'b1;
        run_two <= 1'b1;
        tick(5);
        chk_bit(apd, 1'b1);
        chk_bit(wpd, 1'b0);
        chk_mode(mode, SRMC_LOCKOUT);
        $display("test lockout done");
    endtask : t_lockout

    task automatic t_run;
        logic s1, s2;
        // Enter run just after channel one's drain rises: it is armed
        // before its first conduction, which must still give no gate
        for (int i = 0; i < 200 && cd1 !== 1'b1; i++) tick(1);
        for (int i = 0; i < 200 && ds1 !== 1'b1; i++) tick(1);
        @(posedge clk);
        on_r <= 1'b1;
        wait_mode(SRMC_RUN, 5);
        chk_bit(loc, 1'b0);
        chk_bit(sbc, 1'b0);
        for (int p = 0; p < 2; p++) begin
            s1 = 1'b0;
            s2 = 1'b0;
            for (int i = 0; i < 200 && cd1 !== 1'b1; i++) tick(1);
            repeat (80) begin
                tick(1);
                s1 |= g1;
                s2 |= g2;
            end
            if (p == 0) chk_bit(s1, 1'b0);
            else begin
                chk_bit(s1, 1'b1);
                chk_bit(s2, 1'b1);
            end
        end
        tick(2 * QCYC);
        chk_mode(mode, SRMC_RUN);
        $display("test run done");
    endtask : t_run

    task automatic t_standby;
        @(posedge clk);
        run_one <= 1'b0;
        run_two <= 1'b0;
        wait_mode(SRMC_STANDBY, 3 * QCYC);
        chk_bit(sbc, 1'b1);
        chk_bit(apd, 1'b1);
        @(posedge clk);
        run_two <= 1'b1;
        tick(3 * QCYC);
        chk_mode(mode, SRMC_STANDBY);
        @(posedge clk);
        run_one <= 1'b1;
        wait_mode(SRMC_RUN, 3 * QCYC);
        $display("test standby done");
    endtask : t_standby

    task automatic t_drop;
        @(posedge clk);
        on_r <= 1'b0;
        tick(3);
        chk_mode(mode, SRMC_RUN);
        @(posedge clk);
        off_r   <= 1'b0;
        run_one <= 1'b0;
        // Channel two keeps switching; channel one stays stopped after rail on
        tick(2);
        chk_mode(mode, SRMC_LOCKOUT);
        chk_bit(loc, 1'b1);
        chk_bit(apd, 1'b1);
        @(posedge clk);
        v2_r <= 1'b0;
        tick(2);
        chk_bit(wpd, 1'b1);
        @(posedge clk);
        v2_r  <= 1'b1;
        off_r <= 1'b1;
        on_r  <= 1'b1;
        wait_mode(SRMC_RUN, 5);
        tick(QCYC - 5);
        chk_mode(mode, SRMC_RUN);
        wait_mode(SRMC_STANDBY, 10);
        $display("test drop done");
    endtask : t_drop

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        tick(1);
        t_lockout();
        t_run();
        t_standby();
        t_drop();
        test_done();
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule : test_sr_operating_mode_controller
`default_nettype wire
